// file: core/tzs_pkg.sv
package tzs_pkg;

    // Byte and window geometry
    localparam int TZS_BYTE_W = 8;
    localparam int TZS_FIFO_DEPTH = 16;
    localparam int TZS_BPV_W = 16;
    localparam logic [2:0] TZS_BIT_FIRST = 3'h0;
    localparam logic [2:0] TZS_BIT_LAST = 3'h7;

    // Channel byte values, sent MSB first
    localparam logic [7:0] TZS_ZERO_BYTE = 8'h00;
    localparam logic [7:0] TZS_ALL_ONES = 8'hff;
    localparam logic [7:0] TZS_B7_FORCE = 8'h02;

    // T1DM channel 24 byte: sync ones at 0,2,3,4; zeros at 1,7
    localparam logic [7:0] TZS_T1DM_SYNC = 8'h1d;
    localparam int TZS_T1DM_YEL_BIT = 5;
    localparam int TZS_T1DM_DL_BIT = 6;

    // Substitution slot indices, 0 based: violations at 3 and 6
    localparam logic [2:0] TZS_SUB_V1 = 3'h3;
    localparam logic [2:0] TZS_SUB_B1 = 3'h4;
    localparam logic [2:0] TZS_SUB_V2 = 3'h6;
    localparam logic [2:0] TZS_SUB_B2 = 3'h7;

    // Line density limit
    localparam logic [4:0] TZS_MAX_ZERO_RUN = 5'h0f;

    typedef struct packed {
        logic ch24;
        logic link_bit;
        logic [7:0] data;
    } tzs_tx_word_t;

    typedef struct packed {
        logic pos;
        logic neg;
    } tzs_rail_t;

    typedef enum logic [0:0] {
        TZS_LINE_PASS = 1'b0,
        TZS_LINE_SUB = 1'b1
    } tzs_line_st_t;

    // Rail for slot idx of a substitution code, s = last mark was positive
    function automatic tzs_rail_t tzs_sub_rail(input logic [2:0] idx, input logic s);
        tzs_rail_t r;
        r = '0;
        if (idx == TZS_SUB_V1 || idx == TZS_SUB_B2) begin
            r = '{pos: s, neg: ~s};
        end else if (idx == TZS_SUB_B1 || idx == TZS_SUB_V2) begin
            r = '{pos: ~s, neg: s};
        end
        return r;
    endfunction

endpackage

// file: core/tzs_fifo.sv
`timescale 1ns/10ps
module tzs_fifo import tzs_pkg::*; #(
    parameter int W = 10,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Fill side
    input wire logic i_wr_valid,
    input wire logic [W-1:0] i_wr_data,
    output logic o_wr_ready,
    // Drain side
    output logic o_rd_valid,
    output logic [W-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic rd_valid_reg;
    logic [W-1:0] rd_data_reg;
    logic push;
    logic load;

    assign o_wr_ready = count_reg != CW'(DEPTH);
    assign push = i_wr_valid && o_wr_ready;
    // Output stage refills only when free or being taken
    assign load = (count_reg != '0) && (!rd_valid_reg || i_rd_ready);
    assign o_rd_valid = rd_valid_reg;
    assign o_rd_data = rd_data_reg;

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_wr_data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            end
            if (load) begin
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            end
            count_reg <= count_reg + CW'(push) - CW'(load);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg <= '0;
        end else if (load) begin
            rd_valid_reg <= 1'b1;
            rd_data_reg <= mem[rd_ptr_reg];
        end else if (i_rd_ready) begin
            rd_valid_reg <= 1'b0;
        end
    end

endmodule

// file: core/tzs_rx_decode.sv
`timescale 1ns/10ps
module tzs_rx_decode import tzs_pkg::*; (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Line side
    input wire logic i_rx_tick,
    input wire tzs_rail_t i_rx_rail,
    input wire logic i_decode_on,
    // Decoded side
    output logic o_data,
    output logic o_valid,
    output logic o_sub_event,
    output logic o_bpv
);
    tzs_rail_t win_reg [TZS_BYTE_W];
    logic [TZS_BYTE_W-1:0] mask_reg;
    logic last_pos_reg;
    logic [TZS_BYTE_W-1:0] slot_ok;
    logic detect;
    logic [TZS_BYTE_W-1:0] mask_eff;
    tzs_rail_t exit_rail;
    logic exit_mark;

    // Slot k of the code sits at window index 7-k, oldest first
    genvar k;
    generate
        for (k = 0; k < TZS_BYTE_W; k++) begin : g_slot
            assign slot_ok[k] = win_reg[TZS_BYTE_W-1-k] == tzs_sub_rail(3'(k), last_pos_reg);
        end
    endgenerate

    // Monitored regardless of decode setting
    assign detect = i_rx_tick && (&slot_ok) && (mask_reg == '0);
    assign mask_eff = detect ? TZS_ALL_ONES : mask_reg;
    // Decoded code leaves as zeros before anything else sees it
    assign exit_rail = (mask_eff[TZS_BYTE_W-1] && i_decode_on) ? tzs_rail_t'('0)
                       : win_reg[TZS_BYTE_W-1];
    assign exit_mark = exit_rail.pos || exit_rail.neg;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < TZS_BYTE_W; i++) begin
                win_reg[i] <= '0;
            end
            mask_reg <= '0;
        end else if (i_rx_tick) begin
            for (int i = 1; i < TZS_BYTE_W; i++) begin
                win_reg[i] <= (mask_eff[i-1] && i_decode_on) ? tzs_rail_t'('0) : win_reg[i-1];
            end
            win_reg[0] <= i_rx_rail;
            mask_reg <= {mask_eff[TZS_BYTE_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            last_pos_reg <= 1'b0;
            o_data <= 1'b0;
            o_valid <= 1'b0;
            o_sub_event <= 1'b0;
            o_bpv <= 1'b0;
        end else begin
            o_valid <= i_rx_tick;
            o_sub_event <= detect;
            o_bpv <= 1'b0;
            if (i_rx_tick) begin
                o_data <= exit_mark;
                // Code marks neither flip polarity nor count
                if (exit_mark && !mask_eff[TZS_BYTE_W-1]) begin
                    last_pos_reg <= exit_rail.pos;
                    o_bpv <= exit_rail.pos == last_pos_reg;
                end
            end
        end
    end

    a_rx_zeroed: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        detect && i_decode_on |=> !o_data)
        else $error("decoded code slot not zero");
    a_bpv_masked: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_rx_tick && mask_eff[TZS_BYTE_W-1] |=> !o_bpv)
        else $error("code violation counted");
    a_detect_shape: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        detect |-> win_reg[TZS_BYTE_W-4].pos == last_pos_reg && win_reg[1].pos != last_pos_reg
        && win_reg[TZS_BYTE_W-4].pos != win_reg[TZS_BYTE_W-4].neg)
        else $error("code accepted without violations");

endmodule

// file: core/tzs_codec.sv
`timescale 1ns/10ps
// Behaviour
// - Bit-7 suppression on: all-zero channel byte gets its second LSB forced.
// - Encoder on: every eight pending zeros are replaced by substitution code.
// - Code is 000+-0-+ after positive mark, 000-+0+- after negative.
// - Decoder active: received code becomes eight zeros before other processing.
// - Codes always watched; reported in sticky flag when status select is 0.
// - Revised variant keeps the decoder always on; enable steers encoder only.
// - Violations inside a recognised code never advance the violation counter.
// - T1DM channel 24 carries ones at bits 0,2,3,4, zeros at 1,7.
// - T1DM channel 24 bit 5 carries yellow alarm, 0 means alarm.
// - T1DM channel 24 bit 6 carries the auxiliary data link bit.
// - Loss of signal or loopback makes the transmitter send all ones.
// - While red alarm persists, yellow alarm is sent back, on the line only in T1DM channel 24.
// - Encoder on: sent stream keeps ones density, never over fifteen zeros in a row.
module tzs_codec import tzs_pkg::*; #(
    parameter int FIFO_DEPTH = TZS_FIFO_DEPTH,
    parameter int BPV_W = TZS_BPV_W,
    parameter bit REVISED_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Host control levels
    input wire logic i_bit7_suppress,
    input wire logic i_substitution_encode_enable,
    input wire logic i_status_select_bit,
    input wire logic i_t1dm_mode,
    input wire logic i_loss_of_signal,
    input wire logic i_loopback,
    input wire logic i_red_alarm,
    input wire logic i_seen_flag_clear,
    input wire logic i_bpv_count_clear,
    // Transmit channel bytes
    input wire logic i_tx_valid,
    input wire tzs_tx_word_t i_tx_word,
    output logic o_tx_ready,
    // Transmit line
    input wire logic i_tx_tick,
    output logic o_tx_pos,
    output logic o_tx_neg,
    // Receive line
    input wire logic i_rx_tick,
    input wire logic i_rx_pos,
    input wire logic i_rx_neg,
    // Receive results and status
    output logic o_rx_data,
    output logic o_rx_valid,
    output logic o_substitution_seen_flag,
    output logic [BPV_W-1:0] o_bpv_count,
    output logic o_yellow_alarm,
    output logic o_ais_active
);
    localparam int WW = $bits(tzs_tx_word_t);

    logic fifo_valid;
    tzs_tx_word_t fifo_word;
    logic fifo_take;
    logic ais;
    logic [TZS_BYTE_W-1:0] fill_byte;
    logic [TZS_BYTE_W-1:0] byte_reg;
    logic [2:0] bit_cnt_reg;
    logic [TZS_BYTE_W-1:0] win_reg;
    tzs_line_st_t line_st_reg;
    logic [2:0] sub_idx_reg;
    logic sub_sgn_reg;
    logic last_pos_reg;
    logic sub_start;
    tzs_rail_t line_rail;
    logic yellow_reg;
    logic ais_reg;
    logic rx_sub_event;
    logic rx_bpv;
    tzs_rail_t rx_rail;
    logic decode_on;
    logic [4:0] zero_run_reg;

    // Channel 24 sync byte with alarm and link bits
    function automatic logic [7:0] t1dm_ch24(input logic yellow, input logic link);
        logic [7:0] b;
        b = TZS_T1DM_SYNC;
        b[TZS_T1DM_YEL_BIT] = ~yellow;
        b[TZS_T1DM_DL_BIT] = link;
        return b;
    endfunction

    // Buffer absorbs host bursts; line tick drains one byte per eight bits
    tzs_fifo #(
        .W(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_wr_valid(i_tx_valid),
        .i_wr_data(i_tx_word),
        .o_wr_ready(o_tx_ready),
        .o_rd_valid(fifo_valid),
        .o_rd_data(fifo_word),
        .i_rd_ready(fifo_take)
    );

    assign ais = i_loss_of_signal || i_loopback;
    assign fifo_take = i_tx_tick && (bit_cnt_reg == TZS_BIT_LAST);

    // Next byte to serialise; an empty buffer sends ones to keep density
    always_comb begin
        fill_byte = TZS_ALL_ONES;
        if (ais) begin
            fill_byte = TZS_ALL_ONES;
        end else if (fifo_valid) begin
            if (i_t1dm_mode && fifo_word.ch24) begin
                fill_byte = t1dm_ch24(yellow_reg, fifo_word.link_bit);
            end else if (i_bit7_suppress && fifo_word.data == TZS_ZERO_BYTE) begin
                fill_byte = TZS_B7_FORCE;
            end else begin
                fill_byte = fifo_word.data;
            end
        end
    end

    // Serialiser, MSB first
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            byte_reg <= TZS_ALL_ONES;
            bit_cnt_reg <= TZS_BIT_FIRST;
        end else if (i_tx_tick) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == TZS_BIT_LAST) begin
                byte_reg <= fill_byte;
            end else begin
                byte_reg <= {byte_reg[TZS_BYTE_W-2:0], 1'b0};
            end
        end
    end

    // Eight-bit lookahead; costs eight bits of latency on the line
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            win_reg <= TZS_ALL_ONES;
        end else if (i_tx_tick) begin
            win_reg <= {win_reg[TZS_BYTE_W-2:0], byte_reg[TZS_BYTE_W-1]};
        end
    end

    // Window holds exactly the eight pending zeros
    assign sub_start = i_tx_tick && line_st_reg == TZS_LINE_PASS
                       && i_substitution_encode_enable && win_reg == TZS_ZERO_BYTE;

    always_comb begin
        line_rail = '0;
        if (sub_start) begin
            line_rail = tzs_sub_rail(TZS_BIT_FIRST, last_pos_reg);
        end else if (line_st_reg == TZS_LINE_SUB) begin
            line_rail = tzs_sub_rail(sub_idx_reg, sub_sgn_reg);
        end else if (win_reg[TZS_BYTE_W-1]) begin
            line_rail = '{pos: ~last_pos_reg, neg: last_pos_reg};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            line_st_reg <= TZS_LINE_PASS;
            sub_idx_reg <= TZS_BIT_FIRST;
            sub_sgn_reg <= 1'b0;
        end else if (sub_start) begin
            line_st_reg <= TZS_LINE_SUB;
            sub_idx_reg <= TZS_BIT_FIRST + 3'h1;
            sub_sgn_reg <= last_pos_reg;
        end else if (i_tx_tick && line_st_reg == TZS_LINE_SUB) begin
            sub_idx_reg <= sub_idx_reg + 3'h1;
            if (sub_idx_reg == TZS_BIT_LAST) begin
                line_st_reg <= TZS_LINE_PASS;
            end
        end
    end

    // Polarity memory follows every mark sent
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            last_pos_reg <= 1'b0;
        end else if (i_tx_tick && (line_rail.pos || line_rail.neg)) begin
            last_pos_reg <= line_rail.pos;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_pos <= 1'b0;
            o_tx_neg <= 1'b0;
        end else if (i_tx_tick) begin
            o_tx_pos <= line_rail.pos;
            o_tx_neg <= line_rail.neg;
        end
    end

    // Alarm levels
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            yellow_reg <= 1'b0;
            ais_reg <= 1'b0;
        end else begin
            yellow_reg <= i_red_alarm;
            ais_reg <= ais;
        end
    end

    assign o_yellow_alarm = yellow_reg;
    assign o_ais_active = ais_reg;

    // Receive side
    assign decode_on = REVISED_VARIANT || i_substitution_encode_enable;
    assign rx_rail = '{pos: i_rx_pos, neg: i_rx_neg};

    tzs_rx_decode u_rx (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_rx_tick(i_rx_tick),
        .i_rx_rail(rx_rail),
        .i_decode_on(decode_on),
        .o_data(o_rx_data),
        .o_valid(o_rx_valid),
        .o_sub_event(rx_sub_event),
        .o_bpv(rx_bpv)
    );

    // Sticky report; a new event beats a clear in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_substitution_seen_flag <= 1'b0;
        end else if (rx_sub_event && !i_status_select_bit) begin
            o_substitution_seen_flag <= 1'b1;
        end else if (i_seen_flag_clear) begin
            o_substitution_seen_flag <= 1'b0;
        end
    end

    // Saturating so a stuck line never wraps to a small count
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bpv_count <= '0;
        end else if (rx_bpv && o_bpv_count != '1) begin
            o_bpv_count <= o_bpv_count + BPV_W'(1);
        end else if (i_bpv_count_clear && !rx_bpv) begin
            o_bpv_count <= '0;
        end
    end

    // Zero-run watch for the density check
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            zero_run_reg <= '0;
        end else if (!i_substitution_encode_enable) begin
            zero_run_reg <= '0;
        end else if (i_tx_tick) begin
            zero_run_reg <= (line_rail.pos || line_rail.neg) ? 5'h00 : zero_run_reg + 5'h01;
        end
    end

    sequence s_sub_begin;
        sub_start;
    endsequence

    sequence s_viol_slot;
        i_tx_tick && line_st_reg == TZS_LINE_SUB && sub_idx_reg == TZS_SUB_V1;
    endsequence

    a_b7_force: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        fifo_take && !ais && fifo_valid && i_bit7_suppress && !(i_t1dm_mode && fifo_word.ch24)
        && fifo_word.data == TZS_ZERO_BYTE |=> byte_reg == TZS_B7_FORCE)
        else $error("all-zero byte not forced");
    a_sub_entry: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        s_sub_begin |=> line_st_reg == TZS_LINE_SUB && sub_idx_reg == 3'h1
        && sub_sgn_reg == $past(last_pos_reg) && !o_tx_pos && !o_tx_neg)
        else $error("substitution not started");
    a_sub_viol: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        s_viol_slot |=> o_tx_pos == sub_sgn_reg && o_tx_neg == !sub_sgn_reg
        && o_tx_pos == $past(last_pos_reg))
        else $error("violation slot wrong polarity");
    a_polarity_track: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_tx_tick && line_rail.neg |=> !last_pos_reg && o_tx_neg)
        else $error("polarity memory not updated");
    a_ch24_sync: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        fifo_take && !ais && fifo_valid && i_t1dm_mode && fifo_word.ch24
        |=> (byte_reg & 8'h9f) == TZS_T1DM_SYNC
        && byte_reg[TZS_T1DM_YEL_BIT] == !$past(yellow_reg))
        else $error("channel 24 byte malformed");
    a_ais_ones: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        fifo_take && ais |=> byte_reg == TZS_ALL_ONES)
        else $error("alarm indication not all ones");
    a_yellow_red: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_red_alarm [*2] |-> o_yellow_alarm)
        else $error("yellow not sent during red alarm");
    a_zero_run: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        zero_run_reg <= TZS_MAX_ZERO_RUN)
        else $error("zero run too long");
    a_seen_flag: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        rx_sub_event && !i_status_select_bit |=> o_substitution_seen_flag)
        else $error("substitution not reported");

endmodule

// file: tb/tzs_line_model.sv
`timescale 1ns/10ps
module tzs_line_model import tzs_pkg::*; #(
    parameter int GAP = 3
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Bench control
    input wire logic i_run,
    input wire logic i_inject,
    input wire tzs_rail_t i_inj_rail,
    // Codec transmit rails
    input wire logic i_tx_pos,
    input wire logic i_tx_neg,
    // Bit ticks and receive rails
    output logic o_tick,
    output logic o_rx_pos,
    output logic o_rx_neg
);
    logic [3:0] gap_reg;
    logic junk_reg;

    // Ticks move on the falling edge, clear of the codec's sampling edge
    always @(negedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gap_reg <= 4'h0;
            o_tick <= 1'b0;
            junk_reg <= 1'b0;
        end else begin
            gap_reg <= (gap_reg == GAP[3:0]) ? 4'h0 : gap_reg + 4'h1;
            o_tick <= i_run && (gap_reg == 4'h0);
            junk_reg <= ~junk_reg;
        end
    end

    // Outside a tick the rails toggle, so a stale bit can never pass
    assign o_rx_pos = o_tick ? (i_inject ? i_inj_rail.pos : i_tx_pos) : junk_reg;
    assign o_rx_neg = o_tick ? (i_inject ? i_inj_rail.neg : i_tx_neg) : ~junk_reg;
endmodule

// file: tb/tzs_codec_tb.sv
`timescale 1ns/10ps
module tzs_codec_tb import tzs_pkg::*;;
    logic clk, rstn, b7_on, sub_en, stat_sel, t1dm_on, los, lpb, red_in, seen_clr, bpv_clr;
    logic tx_valid, tx_ready, tick, tx_pos, tx_neg, rx_pos, rx_neg, rx_data, rx_valid, seen, yellow, ais;
    logic run_en, inj;
    tzs_tx_word_t tx_word;
    tzs_rail_t inj_rail;
    logic [TZS_BPV_W-1:0] bpv, c0;
    logic [31:0] seed;
    logic eq[$];
    logic rxq[$];
    logic [1:0] lq[$];
    logic [1:0] code_q[$] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h2};
    int err_total, checks, cyc, zc;

    tzs_codec u_tzs_codec (.i_sys_clk(clk), .i_resetn(rstn), .i_bit7_suppress(b7_on),
        .i_substitution_encode_enable(sub_en), .i_status_select_bit(stat_sel), .i_t1dm_mode(t1dm_on),
        .i_loss_of_signal(los), .i_loopback(lpb), .i_red_alarm(red_in), .i_seen_flag_clear(seen_clr),
        .i_bpv_count_clear(bpv_clr), .i_tx_valid(tx_valid), .i_tx_word(tx_word), .o_tx_ready(tx_ready),
        .i_tx_tick(tick), .o_tx_pos(tx_pos), .o_tx_neg(tx_neg), .i_rx_tick(tick), .i_rx_pos(rx_pos),
        .i_rx_neg(rx_neg), .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_substitution_seen_flag(seen),
        .o_bpv_count(bpv), .o_yellow_alarm(yellow), .o_ais_active(ais));

    tzs_line_model u_tzs_line_model (.i_sys_clk(clk), .i_resetn(rstn), .i_run(run_en), .i_inject(inj),
        .i_inj_rail(inj_rail), .i_tx_pos(tx_pos), .i_tx_neg(tx_neg), .o_tick(tick), .o_rx_pos(rx_pos),
        .o_rx_neg(rx_neg));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task tally_and_finish();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen_v, input logic [31:0] exp_v, input string what);
        checks++;
        if (seen_v !== exp_v) begin
            err_total++;
            $display("BAD at %0t: %s saw %h want %h", $time, what, seen_v, exp_v);
        end
    endtask

    // Line symbols at each tick, decoded bits at each valid; cycle ceiling
    always @(posedge clk) begin
        if (tick === 1'b1) lq.push_back({tx_pos, tx_neg});
        if (rx_valid === 1'b1) rxq.push_back(rx_data);
        cyc++;
        if (cyc == 40000) begin
            check(1'b0, 1'b1, "timeout");
            tally_and_finish();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    function automatic logic [7:0] exp_byte(input tzs_tx_word_t w);
        logic [7:0] b;
        b = w.data;
        if (t1dm_on && w.ch24) begin
            b = 8'h1d;
            b[5] = ~red_in;
            b[6] = w.link_bit;
        end else if (b7_on && w.data == 8'h00) begin
            b = 8'h02;
        end
        return b;
    endfunction

    // Decoders lag, so the expected bits are searched for in the stream
    function automatic logic contains();
        int k;
        for (int s = 0; s + eq.size() <= rxq.size(); s++) begin
            for (k = 0; k < eq.size() && rxq[s + k] === eq[k]; k++) begin
            end
            if (k == eq.size()) return 1'b1;
        end
        return 1'b0;
    endfunction

    task automatic line_scan(output int codes);
        logic last;
        logic have;
        int run, maxrun, bad, i;
        have = 1'b0;
        last = 1'b0;
        run = 0;
        maxrun = 0;
        bad = 0;
        i = 0;
        codes = 0;
        while (i < lq.size()) begin
            if (i + 8 <= lq.size() && lq[i] == 2'h0 && lq[i + 1] == 2'h0 && lq[i + 2] == 2'h0 && lq[i + 5] == 2'h0
                && lq[i + 3] != 2'h0 && lq[i + 4] != 2'h0 && lq[i + 4] == lq[i + 6] && lq[i + 3] == lq[i + 7]) begin
                if (have) check(lq[i + 3], {last, ~last}, "code polarity");
                have = 1'b1;
                last = lq[i + 7][1];
                codes++;
                run = 0;
                i += 8;
            end else begin
                if (lq[i] == 2'h0) begin
                    run++;
                end else begin
                    if (have && lq[i][1] == last) bad++;
                    have = 1'b1;
                    last = lq[i][1];
                    run = 0;
                end
                if (run > maxrun) maxrun = run;
                i++;
            end
        end
        check(maxrun <= 15, 1'b1, "zero run");
        check(bad, 0, "mark alternation");
    endtask

    task put_word(input tzs_tx_word_t w);
        int n;
        tx_valid = 1'b1;
        tx_word = w;
        n = 0;
        while (tx_ready !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
    endtask

    task inject_sym(input logic [1:0] s);
        inj = 1'b1;
        inj_rail = s;
        @(posedge clk);
        while (tick !== 1'b1) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic run_case(input int n, input logic sub, b7, dm, red, stall);
        tzs_tx_word_t w;
        logic [7:0] b;
        int acc, codes;
        sub_en = sub;
        b7_on = b7;
        t1dm_on = dm;
        red_in = red;
        repeat (60) @(negedge clk);
        eq.delete();
        rxq.delete();
        lq.delete();
        run_en = ~stall;
        acc = 0;
        for (int k = 0; k < n; k++) begin
            seed = xs(seed);
            w.ch24 = dm && (k % 24 == 23);
            w.link_bit = seed[8];
            w.data = (seed[1:0] == 2'h0) ? 8'h00 : seed[23:16];
            if (dm) w.data[0] = 1'b1;
            if (stall && tx_ready !== 1'b1) begin
                tx_valid = 1'b0;
                @(negedge clk);
            end else begin
                acc++;
                b = exp_byte(w);
                for (int j = 7; j >= 0; j--) eq.push_back(b[j]);
                put_word(w);
            end
        end
        tx_valid = 1'b0;
        if (stall) check(acc, 17, "fifo fill");
        run_en = 1'b1;
        repeat ((n * 8 + 48) * 4) @(negedge clk);
        check(contains(), 1'b1, "decoded stream");
        line_scan(codes);
        check(codes > 0, sub, "code count");
        if (sub) check(seen, 1'b1, "seen flag");
        check(bpv, 0, "violations");
        if (dm) check(yellow, red, "yellow");
    endtask

    initial begin
        {rstn, b7_on, sub_en, stat_sel, t1dm_on, los, lpb, red_in, seen_clr, bpv_clr, tx_valid, inj} = '0;
        tx_word = '0;
        inj_rail = '0;
        run_en = 1'b1;
        seed = 32'h37;
        repeat (3) @(posedge clk);
        check(tx_ready, 1'b1, "ready in reset");
        @(negedge clk);
        rstn = 1'b1;
        run_case(24, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        run_case(24, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        run_case(24, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        run_case(24, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        run_case(20, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        for (int c = 0; c < 2; c++) begin
            los = (c == 0);
            lpb = (c == 1);
            repeat (200) @(negedge clk);
            rxq.delete();
            repeat (6) put_word('0);
            tx_valid = 1'b0;
            repeat (400) @(negedge clk);
            check(ais, 1'b1, "ais flag");
            zc = 0;
            foreach (rxq[k]) if (rxq[k] !== 1'b1) zc++;
            check(zc, 0, "all ones");
            los = 1'b0;
            lpb = 1'b0;
        end
        // Encoder off: decoding here relies on the always-on receiver
        sub_en = 1'b0;
        for (int sel = 0; sel < 2; sel++) begin
            stat_sel = sel[0];
            inject_sym(2'h1);
            inject_sym(2'h2);
            repeat (8) inject_sym(2'h0);
            repeat (2) @(negedge clk);
            c0 = bpv;
            seen_clr = 1'b1;
            @(negedge clk);
            seen_clr = 1'b0;
            foreach (code_q[k]) inject_sym(code_q[k]);
            repeat (8) inject_sym(2'h0);
            repeat (2) @(negedge clk);
            check(seen, !sel[0], "seen flag");
            check(bpv, c0 + 16'h2, "violation count");
        end
        bpv_clr = 1'b1;
        @(negedge clk);
        bpv_clr = 1'b0;
        @(negedge clk);
        check(bpv, 0, "count clear");
        inj = 1'b0;
        tally_and_finish();
    end
endmodule
